/* File: rtl/nv_pkg.sv */
/*
 Package for the nonvolatile byte access sequencer and its CPU-side controller.
 Assumes a 100 MHz CPU clock and a separate calibrated oscillator tick input.
*/
package nv_pkg;
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned ADDR_W           = 9;
	localparam int unsigned DATA_W           = 8;
	localparam int unsigned MEM_DEPTH        = 512;
	localparam logic [2:0]  READ_STALL       = 3'h4;
	localparam logic [2:0]  PROG_STALL       = 3'h2;
	localparam logic [2:0]  ARM_WINDOW       = 3'h4;
	// Programming times in microseconds, counted in oscillator ticks of 1 us
	localparam int unsigned ATOMIC_TIME_US   = 3400;
	localparam int unsigned SPLIT_TIME_US    = 1800;
	localparam logic [7:0]  ERASED_BYTE      = 8'hff;
	localparam logic [5:0]  CTRL_RESET       = 6'h00;
	// Control bit positions
	localparam int unsigned BIT_READ         = 0;
	localparam int unsigned BIT_PROG         = 1;
	localparam int unsigned BIT_MASTER       = 2;
	localparam int unsigned BIT_IRQ_EN       = 3;
	localparam int unsigned BIT_MODE_LO      = 4;
	localparam int unsigned BIT_MODE_HI      = 5;

	typedef enum logic [1:0] {
		MODE_ATOMIC = 2'h0,
		MODE_ERASE  = 2'h1,
		MODE_WRITE  = 2'h2,
		MODE_RSVD   = 2'h3
	} program_mode_field_t;

	// AXI4-Lite offsets of the controller's own registers
	localparam logic [3:0]  OFS_ADDR         = 4'h0;
	localparam logic [3:0]  OFS_DATA         = 4'h4;
	localparam logic [3:0]  OFS_CMD          = 4'h8;
	localparam logic [3:0]  OFS_STAT         = 4'hc;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage : nv_pkg

/* File: rtl/nv_if.sv */
/*
 CPU register port of the sequencer: address, data, control writes and reads.
 Assumes both ends share mclk and rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
interface nv_if;
	logic        addr_we;
	logic [8:0]  addr_wdata;
	logic        data_we;
	logic [7:0]  data_wdata;
	logic        ctrl_we;
	logic [5:0]  ctrl_wdata;
	logic [8:0]  nv_byte_address;
	logic [7:0]  nv_byte_data;
	logic [5:0]  nv_control;
	logic        cpu_stall;
	logic        ready_irq;
	modport device (input addr_we, addr_wdata, data_we, data_wdata, ctrl_we, ctrl_wdata,
		output nv_byte_address, nv_byte_data, nv_control, cpu_stall, ready_irq);
	modport cpu (output addr_we, addr_wdata, data_we, data_wdata, ctrl_we, ctrl_wdata,
		input nv_byte_address, nv_byte_data, nv_control, cpu_stall, ready_irq);
endinterface : nv_if
`default_nettype wire

/* File: rtl/nv_sequencer.sv */
/*
 Device end: nonvolatile byte array with read, atomic, erase-only, write-only.
 Assumes the CPU may write address, data and control in one cycle and obeys cpu_stall.
*/
// What this block does
// R1 - Read stalls CPU four cycles
// R2 - Programming start stalls CPU two cycles
// R3 - Mode zero armed enable starts erase-write
// R4 - Program enable held until operation ends
// R5 - No array access while programming
// R6 - Mode 01 erases byte only
// R7 - Mode 10 writes without erasing
// R8 - Software erases before write-only
// R9 - Programming timed by calibrated oscillator
// R10 - Reset does not abort running programming
// R11 - Software polls program enable first
// R12 - Read strobe loads addressed byte into data
// R13 - Software sets mode, address, data, master, enable
// R14 - Master enable self-clears after four cycles
// R15 - Atomic 3.4 ms, split 1.8 ms, 11 reserved
// R16 - Mode writes ignored while prog is set; taken during a run that outlives a reset
// R17 - Ready interrupt level while idle and enabled
// R18 - Address and read strobe ignored while busy
`timescale 1ns/1ps
`default_nettype none
module nv_sequencer (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic osc_tick,
	nv_if.device      bus
);
	typedef struct packed {
		logic [8:0]  address;
		logic [7:0]  data;
		logic [1:0]  mode;
		logic        irq_en;
		logic        master;
		logic [2:0]  master_cnt;
		logic        prog;
		logic [2:0]  stall_cnt;
	} cpu_state_t;

	// Programming state survives reset, so it lives in a reset-free flop group
	typedef struct packed {
		logic        busy;
		logic [1:0]  op;
		logic [11:0] ticks;
		logic [8:0]  addr;
		logic [7:0]  data;
	} prog_state_t;

	cpu_state_t  s;
	cpu_state_t  next_s;
	// Power-up value only; rst_n never touches a run in progress
	prog_state_t p = '0;
	prog_state_t next_p;
	logic [7:0]  mem [0:nv_pkg::MEM_DEPTH-1];
	logic        start;
	logic        done;

	function automatic logic [11:0] op_ticks(input logic [1:0] m);
		op_ticks = (m == nv_pkg::MODE_ATOMIC) ? 12'(nv_pkg::ATOMIC_TIME_US) // [R15]
			: 12'(nv_pkg::SPLIT_TIME_US);
	endfunction : op_ticks

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_p = p;
		start = 1'b0;
		done = p.busy && osc_tick && (p.ticks == 12'h001); // [R9]
		if (s.stall_cnt != 3'h0)
			next_s.stall_cnt = s.stall_cnt - 3'h1;
		if (s.master_cnt != 3'h0)
			next_s.master_cnt = s.master_cnt - 3'h1;
		else
			next_s.master = 1'b0; // [R14]
		if (bus.addr_we && !p.busy)
			next_s.address = bus.addr_wdata; // [R18]
		if (bus.data_we)
			next_s.data = bus.data_wdata;
		if (bus.ctrl_we) begin
			next_s.irq_en = bus.ctrl_wdata[nv_pkg::BIT_IRQ_EN];
			if (!s.prog)
				next_s.mode = bus.ctrl_wdata[nv_pkg::BIT_MODE_HI:nv_pkg::BIT_MODE_LO]; // [R16]
			if (bus.ctrl_wdata[nv_pkg::BIT_MASTER] && !s.master) begin
				next_s.master = 1'b1;
				next_s.master_cnt = nv_pkg::ARM_WINDOW - 3'h1; // [R14]
			end
			if (bus.ctrl_wdata[nv_pkg::BIT_PROG] && s.master && !p.busy
				&& s.mode != nv_pkg::MODE_RSVD) begin // [R3] [R5] [R15]
				start = 1'b1;
				next_s.prog = 1'b1; // [R4]
				next_s.master = 1'b0;
				next_s.master_cnt = 3'h0;
				next_s.stall_cnt = nv_pkg::PROG_STALL; // [R2]
				next_p.busy = 1'b1;
				next_p.op = s.mode;
				next_p.ticks = op_ticks(s.mode);
				// Target kept with the run: a reset clears the CPU-side copies [R10]
				next_p.addr = s.address;
				next_p.data = s.data;
			end else if (bus.ctrl_wdata[nv_pkg::BIT_READ] && !p.busy) begin // [R5] [R18]
				next_s.data = mem[s.address]; // [R12]
				next_s.stall_cnt = nv_pkg::READ_STALL; // [R1]
			end
		end
		if (p.busy && osc_tick)
			next_p.ticks = p.ticks - 12'h001;
		if (done) begin
			next_p.busy = 1'b0;
			next_s.prog = 1'b0; // [R4]
		end
		if (!p.busy && !start)
			next_s.prog = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// No reset: a programming run continues through reset [R10]
	always_ff @(posedge mclk) begin
		p <= next_p;
		if (done) begin
			unique case (p.op)
				nv_pkg::MODE_ATOMIC: mem[p.addr] <= p.data; // [R3]
				nv_pkg::MODE_ERASE:  mem[p.addr] <= nv_pkg::ERASED_BYTE; // [R6]
				nv_pkg::MODE_WRITE:  mem[p.addr] <= mem[p.addr] & p.data; // [R7] [R8]
				default:             mem[p.addr] <= mem[p.addr];
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign bus.nv_byte_address = s.address;
	assign bus.nv_byte_data    = s.data;
	assign bus.nv_control      = {s.mode, s.irq_en, s.master, s.prog | p.busy, 1'b0};
	assign bus.cpu_stall       = (s.stall_cnt != 3'h0);
	assign bus.ready_irq       = s.irq_en && !p.busy; // [R17]
endmodule : nv_sequencer
`default_nettype wire

/* File: rtl/nv_cpu_ctrl.sv */
/*
 CPU end: AXI4-Lite slave taking orders and running the register sequences.
 Assumes one command at a time; software polls the status word.
*/
`timescale 1ns/1ps
`default_nettype none
module nv_cpu_ctrl (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	nv_if.cpu                bus
);
	typedef enum logic [2:0] {IDLE, POLL, SETUP, ARM, FIRE, READ, HOLD} step_t;
	typedef struct packed {
		step_t       step;
		logic [8:0]  addr;
		logic [7:0]  data;
		logic [1:0]  mode;
		logic        is_read;
		logic        irq_en;
		logic        aw_got;
		logic        w_got;
		logic [3:0]  awaddr;
		logic [31:0] wdata;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} state_t;
	state_t s;
	state_t next_s;

	always_comb begin
		next_s = s;
		bus.addr_we = 1'b0;
		bus.addr_wdata = s.addr;
		bus.data_we = 1'b0;
		bus.data_wdata = s.data;
		bus.ctrl_we = 1'b0;
		bus.ctrl_wdata = {s.mode, s.irq_en, 3'h0};
		if (s_axi_awvalid && !s.aw_got) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_got) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = nv_pkg::RESP_OKAY;
			unique case (s.awaddr)
				nv_pkg::OFS_ADDR: next_s.addr = s.wdata[8:0];
				nv_pkg::OFS_DATA: next_s.data = s.wdata[7:0];
				nv_pkg::OFS_CMD: begin
					next_s.irq_en = s.wdata[3];
					if (s.step == IDLE && s.wdata[0]) begin
						next_s.mode = s.wdata[2:1];
						next_s.is_read = s.wdata[4];
						next_s.step = POLL;
					end else if (s.step != IDLE && s.wdata[0])
						next_s.bresp = nv_pkg::RESP_SLVERR;
				end
				default: next_s.bresp = nv_pkg::RESP_SLVERR;
			endcase
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		if (s_axi_arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = nv_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				nv_pkg::OFS_ADDR: next_s.rdata = {23'h0, s.addr};
				nv_pkg::OFS_DATA: next_s.rdata = {24'h0, s.data};
				nv_pkg::OFS_CMD:  next_s.rdata = {27'h0, s.is_read, s.irq_en, s.mode, 1'b0};
				nv_pkg::OFS_STAT: next_s.rdata = {21'h0, bus.ready_irq, bus.nv_control[1],
					bus.nv_byte_data, (s.step != IDLE)};
				default: begin
					next_s.rdata = 32'h0;
					next_s.rresp = nv_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		// Sequence steps; each register write waits out any CPU stall
		if (!bus.cpu_stall) begin
			unique case (s.step)
				IDLE: ;
				POLL: if (!bus.nv_control[1]) next_s.step = SETUP; // [R11]
				SETUP: begin
					bus.addr_we = 1'b1;
					bus.data_we = !s.is_read;
					bus.ctrl_we = !s.is_read;
					next_s.step = s.is_read ? READ : ARM; // [R13]
				end
				ARM: begin
					bus.ctrl_we = 1'b1;
					bus.ctrl_wdata = {s.mode, s.irq_en, 3'h4};
					next_s.step = FIRE;
				end
				FIRE: begin
					bus.ctrl_we = 1'b1;
					bus.ctrl_wdata = {s.mode, s.irq_en, 3'h2}; // [R13]
					next_s.step = HOLD;
				end
				READ: begin
					bus.ctrl_we = 1'b1;
					bus.ctrl_wdata = {s.mode, s.irq_en, 3'h1}; // [R12]
					next_s.step = HOLD;
				end
				HOLD: begin
					next_s.data = bus.nv_byte_data;
					next_s.step = IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = !s.aw_got;
	assign s_axi_wready  = !s.w_got;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
endmodule : nv_cpu_ctrl
`default_nettype wire

/* File: sim/nv_chk_sva.sv */
/* Checker on the link between controller and sequencer.
 Assumes one clock mclk and async active-low rst_n; instantiated by tb. */
`timescale 1ns/1ps
`default_nettype none
module nv_chk_sva (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       osc_tick,
	input wire logic       addr_we,
	input wire logic [8:0] addr_wdata,
	input wire logic       data_we,
	input wire logic [7:0] data_wdata,
	input wire logic       ctrl_we,
	input wire logic [5:0] ctrl_wdata,
	input wire logic [8:0] nv_byte_address,
	input wire logic [7:0] nv_byte_data,
	input wire logic [5:0] nv_control,
	input wire logic       cpu_stall,
	input wire logic       ready_irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// No reset: a run survives reset and keeps its count
	logic [11:0] tick_cnt;
	always_ff @(posedge mclk) begin
		if (nv_control[1]) tick_cnt <= tick_cnt + {11'h0, osc_tick};
		else tick_cnt <= 12'h000;
	end
	////////////////////////////////////////////////////////////////
	property p_rd_stall;
		ctrl_we && ctrl_wdata[0] && !nv_control[1] |=> cpu_stall [*4];
	endproperty
	a_rd_stall: assert property (p_rd_stall) else $error("read stall too short");
	property p_start;
		ctrl_we && ctrl_wdata[1] && nv_control[2] && !nv_control[1] && ctrl_wdata[5:4] != 2'h3
			&& nv_control[5:4] != 2'h3 |=> nv_control[1] && cpu_stall ##1 cpu_stall;
	endproperty
	a_start: assert property (p_start) else $error("armed start missed");
	property p_unarmed;
		ctrl_we && ctrl_wdata[1] && !nv_control[2] && !nv_control[1] |=> !nv_control[1];
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("unarmed start taken");
	property p_master_clr;
		$rose(nv_control[2]) |-> ##[1:5] !nv_control[2];
	endproperty
	a_master_clr: assert property (p_master_clr) else $error("master enable stuck");
	property p_duration;
		$fell(nv_control[1]) |-> (nv_control[5:4] == 2'h0) ? (tick_cnt inside {[3399:3401]})
			: (tick_cnt inside {[1799:1801]});
	endproperty
	a_duration: assert property (p_duration) else $error("busy time wrong");
	property p_mode_hold;
		nv_control[1] && $past(nv_control[1]) |-> $stable(nv_control[5:4]);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed while busy");
	property p_addr_hold;
		nv_control[1] && $past(nv_control[1]) |-> $stable(nv_byte_address);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address changed while busy");
	property p_irq;
		ready_irq == (nv_control[3] && !nv_control[1]);
	endproperty
	a_irq: assert property (p_irq) else $error("ready irq level wrong");
	property p_refuse;
		nv_control[1] && ctrl_we && ctrl_wdata[0] && !data_we |=> $stable(nv_byte_data);
	endproperty
	a_refuse: assert property (p_refuse) else $error("read taken while busy");
	c_prog: cover property ($rose(nv_control[1]));
	c_read: cover property (ctrl_we && ctrl_wdata[0]);
	c_irq: cover property (ready_irq);
endmodule : nv_chk_sva
`default_nettype wire

/* File: sim/tb.sv */
/* Bench: sequencer and controller joined by nv_if, driven over AXI4-Lite.
 Assumes the rtl/ files and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        mclk = 1'b0, rst_n = 1'b0, osc_tick = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'd51700;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          error_cnt = 0, checks = 0;
	nv_if bus ();
	nv_sequencer nv_sequencer_inst (.mclk, .rst_n, .osc_tick, .bus);
	nv_cpu_ctrl nv_cpu_ctrl_inst (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus);
	nv_chk_sva nv_chk_sva_inst (.mclk, .rst_n, .osc_tick, .addr_we(bus.addr_we), .addr_wdata(bus.addr_wdata),
		.data_we(bus.data_we), .data_wdata(bus.data_wdata), .ctrl_we(bus.ctrl_we), .ctrl_wdata(bus.ctrl_wdata),
		.nv_byte_address(bus.nv_byte_address), .nv_byte_data(bus.nv_byte_data), .nv_control(bus.nv_control),
		.cpu_stall(bus.cpu_stall), .ready_irq(bus.ready_irq));
	always #5 mclk = ~mclk;
	// Fast oscillator keeps the long programming times short in cycles
	always @(posedge mclk) osc_tick <= ~osc_tick;
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [7:0] after_op(input logic [1:0] m, input logic [7:0] o, d);
		case (m)
			2'h0: return d;
			2'h1: return nv_pkg::ERASED_BYTE;
			2'h2: return o & d;
			default: return o;
		endcase
	endfunction : after_op
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge mclk);
	endtask : rd
	task automatic idle();
		logic [31:0] s;
		logic [1:0]  r;
		do rd(nv_pkg::OFS_STAT, s, r); while (s[0] !== 1'b0 || s[9] !== 1'b0);
	endtask : idle
	task automatic go(input logic [8:0] a, input logic [7:0] d, input logic [4:0] c);
		logic [1:0] r;
		wr(nv_pkg::OFS_ADDR, {23'h0, a}, r);
		wr(nv_pkg::OFS_DATA, {24'h0, d}, r);
		wr(nv_pkg::OFS_CMD, {27'h0, c}, r);
		chk({30'h0, r}, {30'h0, nv_pkg::RESP_OKAY});
	endtask : go
	task automatic rb(input logic [8:0] a, input logic [7:0] e);
		logic [31:0] s;
		logic [1:0]  r;
		go(a, 8'h00, 5'h11);
		idle();
		rd(nv_pkg::OFS_STAT, s, r);
		chk({24'h0, s[8:1]}, {24'h0, e});
	endtask : rb
	initial begin
		repeat (100000) @(posedge mclk);
		error_cnt++;
		give_verdict();
	end
	initial begin
		logic [8:0]  a;
		logic [7:0]  d, e;
		logic [1:0]  r;
		logic [31:0] s;
		logic [1:0]  mt [5];
		mt = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
		e = 8'h00;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		seed = xs(seed);
		a = seed[8:0];
		for (int i = 0; i < 5; i++) begin
			seed = xs(seed);
			d = seed[7:0];
			go(a, d, {1'b0, i == 4, mt[i], 1'b1});
			idle();
			rd(nv_pkg::OFS_STAT, s, r);
			chk({31'h0, s[10]}, {31'h0, i == 4});
			e = after_op(mt[i], e, d);
			rb(a, e);
		end
		$display("end of test modes");
		wr(4'h2, 32'h0, r);
		chk({30'h0, r}, {30'h0, nv_pkg::RESP_SLVERR});
		rd(4'h6, s, r);
		chk({30'h0, r}, {30'h0, nv_pkg::RESP_SLVERR});
		$display("end of test unmapped");
		seed = xs(seed);
		go(seed[8:0], seed[16:9], 5'h01);
		wr(nv_pkg::OFS_CMD, 32'h1, r);
		chk({30'h0, r}, {30'h0, nv_pkg::RESP_SLVERR});
		repeat (100) @(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(nv_pkg::OFS_STAT, s, r);
		chk({31'h0, s[9]}, 32'h1);
		idle();
		rb(seed[8:0], seed[16:9]);
		$display("end of test reset mid-run");
		give_verdict();
	end
endmodule : tb
`default_nettype wire
